/* File: core/sbm_matrix.sv */
// Two-master bus matrix with address decode, boot remap and SRAM slave
`default_nettype none
`include "sbm_defines.svh"
module sbm_matrix (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Masters
   input wire sbm_pkg::sbm_req_t cpu_req_i,
   output sbm_pkg::sbm_rsp_t cpu_rsp_o,
   input wire sbm_pkg::sbm_req_t dma_req_i,
   output sbm_pkg::sbm_rsp_t dma_rsp_o,
   // Shared external slave port
   output sbm_pkg::sbm_req_t ext_req_o,
   output sbm_pkg::sbm_slave_t ext_sel_o,
   input wire sbm_pkg::sbm_rsp_t ext_rsp_i,
   // Peripheral clock limits
   input wire logic [31:0] lsb_clk_hz_i,
   input wire logic [31:0] hsb_clk_hz_i,
   output logic lsb_clk_ok_o,
   output logic hsb_clk_ok_o,
   // System control
   input wire logic [1:0] vector_table_remap_register_i,
   input wire logic power_down_mode_i,
   output logic [31:0] boot_pc_o,
   output logic last_master_o
);
   import sbm_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   logic rst_s1_r;
   logic rst_sync_r;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_s1_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_sync_r <= rst_s1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Full 32-bit space decode
   function automatic sbm_slave_t decode(input logic [`SBM_AW-1:0] a);
      sbm_slave_t s;
      s = SBM_SL_NONE;
      if (a >= `SBM_SRAM_BASE && a <= `SBM_SRAM_LAST) begin
         s = SBM_SL_SRAM;
      // ROM starts at zero, so only the top bound of ROM and flash is compared
      end else if (a <= `SBM_FLASH_LAST) begin
         s = SBM_SL_MEM;
      end else if (a >= `SBM_RADIO_BASE && a <= `SBM_RADIO_LAST) begin
         s = SBM_SL_RADIO;
      end else if (a >= `SBM_ADC_BASE && a <= `SBM_ADC_LAST) begin
         s = SBM_SL_ADC;
      // Remaining high-speed windows, top stays reserved
      end else if (a >= `SBM_AHB_BASE && a < `SBM_AHB_RSVD) begin
         s = SBM_SL_AHB1;
      end else if (a >= `SBM_HSB_BASE && a <= `SBM_HSB_LAST) begin
         s = SBM_SL_HSB;
      end else if (a >= `SBM_LSB_BASE && a <= `SBM_LSB_LAST) begin
         s = SBM_SL_LSB;
      end
      return s;
   endfunction

   // Little-endian lanes from size and low address
   function automatic logic [3:0] lanes(input logic [1:0] sz, input logic [1:0] lo);
      logic [3:0] m;
      m = 4'h0;
      unique case (sz)
         `SBM_SZ_BYTE: m = 4'h1 << lo;
         `SBM_SZ_HALF: m = lo[1] ? 4'hC : 4'h3;
         default: m = 4'hF;
      endcase
      return m;
   endfunction

   function automatic logic misaligned(input logic [1:0] sz, input logic [1:0] lo);
      return (sz == `SBM_SZ_HALF && lo[0]) || (sz == `SBM_SZ_WORD && lo != 2'h0) || (sz == 2'h3);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Vector fetches redirected by remap setting
   function automatic logic [`SBM_AW-1:0] remap(input logic [`SBM_AW-1:0] a, input logic [1:0] sel);
      logic [`SBM_AW-1:0] r;
      r = a;
      if (a <= `SBM_VEC_SPAN) begin
         unique case (sel)
            `SBM_REMAP_FLASH: r = `SBM_FLASH_BASE | a;
            `SBM_REMAP_SRAM: r = `SBM_SRAM_BASE | a;
            default: r = a;
         endcase
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Arbiter and transfer state
   sbm_state_t state_r, state_nxt;
   logic owner_r, owner_nxt;
   logic last_r, last_nxt;
   sbm_req_t cur_r, cur_nxt;
   sbm_slave_t sel_r, sel_nxt;
   logic [1:0] lo_r, lo_nxt;
   sbm_req_t win_req;
   logic win;
   logic grant;
   logic [`SBM_AW-1:0] eff_addr;
   sbm_slave_t win_sel;
   logic done;
   logic [`SBM_DW-1:0] sram_rdata;
   logic [`SBM_DW-1:0] rsp_data;

   // Rotate priority away from the last winner
   always_comb begin
      win = 1'b0;
      if (cpu_req_i.valid && dma_req_i.valid) begin
         win = ~last_r;
      end else if (dma_req_i.valid) begin
         win = 1'b1;
      end
      // Processor path; DMA through the same decode
      win_req = win ? dma_req_i : cpu_req_i;
      grant = (state_r == SBM_ST_IDLE) && (cpu_req_i.valid || dma_req_i.valid);
      eff_addr = remap(win_req.addr, vector_table_remap_register_i);
      win_sel = decode(eff_addr);
   end

   // SRAM answers one cycle after acceptance; others wait for ready
   assign done = (sel_r == SBM_SL_SRAM) ? 1'b1 : ext_rsp_i.ready;

   always_comb begin
      state_nxt = state_r;
      owner_nxt = owner_r;
      last_nxt = last_r;
      cur_nxt = cur_r;
      sel_nxt = sel_r;
      lo_nxt = lo_r;
      unique case (state_r)
         SBM_ST_IDLE: begin
            if (grant) begin
               owner_nxt = win;
               last_nxt = win;
               cur_nxt = win_req;
               cur_nxt.addr = eff_addr;
               sel_nxt = win_sel;
               lo_nxt = eff_addr[1:0];
               // Unmapped or misaligned turns into an error
               if (win_sel == SBM_SL_NONE || misaligned(win_req.size, eff_addr[1:0])) begin
                  state_nxt = SBM_ST_ERR;
               end else begin
                  state_nxt = SBM_ST_BUSY;
               end
            end
         end
         SBM_ST_BUSY: begin
            if (done) begin
               state_nxt = SBM_ST_IDLE;
               cur_nxt.valid = 1'b0;
            end
         end
         SBM_ST_ERR: begin
            state_nxt = SBM_ST_IDLE;
            cur_nxt.valid = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         state_r <= SBM_ST_IDLE;
         owner_r <= 1'b0;
         last_r <= 1'b1;
         cur_r <= '0;
         sel_r <= SBM_SL_NONE;
         lo_r <= 2'h0;
      end else begin
         state_r <= state_nxt;
         owner_r <= owner_nxt;
         last_r <= last_nxt;
         cur_r <= cur_nxt;
         sel_r <= sel_nxt;
         lo_r <= lo_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // SRAM shared by both masters at the system clock
   sbm_sram u_sram (
      .clk_i(clk_i),
      .rst_n_i(rst_sync_r),
      .sel_i(grant && win_sel == SBM_SL_SRAM && !misaligned(win_req.size, eff_addr[1:0])),
      .write_i(win_req.write),
      .be_i(lanes(win_req.size, eff_addr[1:0])),
      .idx_i(eff_addr[`SBM_SRAM_IW+1:2]),
      .wdata_i(win_req.wdata),
      .rdata_o(sram_rdata),
      .power_down_mode_i(power_down_mode_i)
   );

   ////////////////////////////////////////////////////////////////////////
   // One shared request port toward the remaining slaves
   always_comb begin
      ext_req_o = cur_r;
      ext_req_o.valid = (state_r == SBM_ST_BUSY) && (sel_r != SBM_SL_SRAM);
      ext_sel_o = (state_r == SBM_ST_BUSY) ? sel_r : SBM_SL_NONE;
      rsp_data = (sel_r == SBM_SL_SRAM) ? sram_rdata : ext_rsp_i.rdata;
   end

   always_comb begin
      cpu_rsp_o = '0;
      dma_rsp_o = '0;
      if (state_r == SBM_ST_BUSY && done) begin
         if (owner_r) begin
            dma_rsp_o.ready = 1'b1;
            dma_rsp_o.error = (sel_r != SBM_SL_SRAM) && ext_rsp_i.error;
            dma_rsp_o.rdata = rsp_data;
         end else begin
            cpu_rsp_o.ready = 1'b1;
            cpu_rsp_o.error = (sel_r != SBM_SL_SRAM) && ext_rsp_i.error;
            cpu_rsp_o.rdata = rsp_data;
         end
      // Error answer one cycle after acceptance
      end else if (state_r == SBM_ST_ERR) begin
         cpu_rsp_o.ready = !owner_r;
         cpu_rsp_o.error = !owner_r;
         dma_rsp_o.ready = owner_r;
         dma_rsp_o.error = owner_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bridge clock limit checks
   assign lsb_clk_ok_o = lsb_clk_hz_i <= `SBM_LSB_MAX_HZ;
   assign hsb_clk_ok_o = hsb_clk_hz_i <= `SBM_HSB_MAX_HZ;
   // Boot ROM hands over to flash start
   assign boot_pc_o = `SBM_BOOT_PC;
   assign last_master_o = last_r;
endmodule // sbm_matrix
`default_nettype wire

/* File: common/sbm_defines.svh */
// Address map, sizes and widths of the system bus matrix
`ifndef SBM_DEFINES_SVH
`define SBM_DEFINES_SVH

`define SBM_AW 32
`define SBM_DW 32
`define SBM_SRAM_BASE 32'h2000_0000
`define SBM_SRAM_LAST 32'h2000_BFFF
`define SBM_SRAM_WORDS 12288
`define SBM_SRAM_IW 14
`define SBM_FLASH_BASE 32'h0100_0000
`define SBM_FLASH_LAST 32'h01FF_FFFF
`define SBM_ROM_BASE 32'h0000_0000
`define SBM_ROM_LAST 32'h00FF_FFFF
`define SBM_AHB_BASE 32'h4002_0000
`define SBM_RADIO_BASE 32'h4002_8000
`define SBM_RADIO_LAST 32'h4002_BFFF
`define SBM_AHB_RSVD 32'h4002_C000
`define SBM_HSB_BASE 32'h4001_0000
`define SBM_HSB_LAST 32'h4001_47FF
`define SBM_LSB_BASE 32'h4000_0400
`define SBM_LSB_LAST 32'h4000_73FF
`define SBM_ADC_BASE 32'h4002_0800
`define SBM_ADC_LAST 32'h4002_0BFF
`define SBM_WIN_SHIFT 10
`define SBM_WIN_MASK 32'h0000_03FF
`define SBM_BOOT_PC 32'h0100_0000
`define SBM_VEC_SPAN 32'h0000_00FF
`define SBM_LSB_MAX_HZ 32000000
`define SBM_HSB_MAX_HZ 64000000
`define SBM_SYS_HZ 100000000
`define SBM_SZ_BYTE 2'h0
`define SBM_SZ_HALF 2'h1
`define SBM_SZ_WORD 2'h2
`define SBM_REMAP_ROM 2'h0
`define SBM_REMAP_FLASH 2'h1
`define SBM_REMAP_SRAM 2'h2

`endif

/* File: common/sbm_pkg.sv */
// Types shared by the system bus matrix files
`default_nettype none
package sbm_pkg;
`include "sbm_defines.svh"

   typedef struct packed {
      logic valid;
      logic write;
      logic [1:0] size;
      logic [`SBM_AW-1:0] addr;
      logic [`SBM_DW-1:0] wdata;
   } sbm_req_t;

   typedef struct packed {
      logic ready;
      logic error;
      logic [`SBM_DW-1:0] rdata;
   } sbm_rsp_t;

   typedef enum logic [7:0] {
      SBM_SL_NONE = 8'h01,
      SBM_SL_SRAM = 8'h02,
      SBM_SL_RADIO = 8'h04,
      SBM_SL_ADC = 8'h08,
      SBM_SL_AHB1 = 8'h10,
      SBM_SL_HSB = 8'h20,
      SBM_SL_LSB = 8'h40,
      SBM_SL_MEM = 8'h80
   } sbm_slave_t;

   typedef enum logic [2:0] {
      SBM_ST_IDLE = 3'h1,
      SBM_ST_BUSY = 3'h2,
      SBM_ST_ERR = 3'h4
   } sbm_state_t;

endpackage
`default_nettype wire

/* File: core/sbm_sram.sv */
// 48KB single-cycle SRAM slave with byte lanes
`default_nettype none
`include "sbm_defines.svh"
module sbm_sram (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Access
   input wire logic sel_i,
   input wire logic write_i,
   input wire logic [3:0] be_i,
   input wire logic [`SBM_SRAM_IW-1:0] idx_i,
   input wire logic [`SBM_DW-1:0] wdata_i,
   output logic [`SBM_DW-1:0] rdata_o,
   // Retention control
   input wire logic power_down_mode_i
);
   logic [`SBM_DW-1:0] mem [0:`SBM_SRAM_WORDS-1];
   logic [`SBM_DW-1:0] rdata_r;

   always_ff @(posedge clk_i) begin
      if (sel_i && write_i && !power_down_mode_i) begin
         for (int b = 0; b < 4; b++) begin
            if (be_i[b]) begin
               mem[idx_i][b*8 +: 8] <= wdata_i[b*8 +: 8];
            end
         end
      end
   end

   // Contents unreadable once power is removed
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_r <= 32'h0000_0000;
      end else if (sel_i && !write_i) begin
         rdata_r <= power_down_mode_i ? 32'h0000_0000 : mem[idx_i];
      end
   end

   assign rdata_o = rdata_r;
endmodule // sbm_sram
`default_nettype wire

/* File: test/sbm_matrix_props.sv */
// Port relations of the bus matrix, bound onto its top module
`default_nettype none
`include "sbm_defines.svh"
module sbm_matrix_props (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Masters
   input wire sbm_pkg::sbm_req_t cpu_req_i,
   input wire sbm_pkg::sbm_rsp_t cpu_rsp_o,
   input wire sbm_pkg::sbm_rsp_t dma_rsp_o,
   // External slave port
   input wire sbm_pkg::sbm_req_t ext_req_o,
   input wire sbm_pkg::sbm_slave_t ext_sel_o,
   input wire sbm_pkg::sbm_rsp_t ext_rsp_i,
   // Clock limits and boot
   input wire logic [31:0] lsb_clk_hz_i,
   input wire logic [31:0] hsb_clk_hz_i,
   input wire logic lsb_clk_ok_o,
   input wire logic hsb_clk_ok_o,
   input wire logic [31:0] boot_pc_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import sbm_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   logic [31:0] ea;
   logic [31:0] ca;
   assign ea = ext_req_o.addr;
   assign ca = cpu_req_i.addr;
   a_one_answer: assert property (cpu_rsp_o.ready |-> !dma_rsp_o.ready)
      else $error("both masters answered at once");
   a_err_ready: assert property ((cpu_rsp_o.error |-> cpu_rsp_o.ready)
      and (dma_rsp_o.error |-> dma_rsp_o.ready))
      else $error("error without ready");
   a_rsvd_err: assert property (cpu_rsp_o.ready && ca >= `SBM_AHB_RSVD && ca <= 32'h4002_FFFF
      |-> cpu_rsp_o.error)
      else $error("reserved window not refused");
   a_sram_local: assert property (ext_req_o.valid |-> !(ea >= `SBM_SRAM_BASE && ea <= `SBM_SRAM_LAST))
      else $error("memory access leaked outward");
   a_lsb_route: assert property (ext_req_o.valid && ea >= `SBM_LSB_BASE && ea <= `SBM_LSB_LAST
      |-> ext_sel_o == SBM_SL_LSB)
      else $error("low speed bridge not selected");
   a_hsb_route: assert property (ext_req_o.valid && ea >= `SBM_HSB_BASE && ea <= `SBM_HSB_LAST
      |-> ext_sel_o == SBM_SL_HSB)
      else $error("high speed bridge not selected");
   a_radio_route: assert property (ext_req_o.valid && ea >= `SBM_RADIO_BASE && ea <= `SBM_RADIO_LAST
      |-> ext_sel_o == SBM_SL_RADIO)
      else $error("radio window not selected");
   a_ext_hold: assert property (ext_req_o.valid && !ext_rsp_i.ready |=> $stable(ext_req_o))
      else $error("pending outward request changed");
   a_ext_answer: assert property (ext_req_o.valid && ext_rsp_i.ready
      |-> cpu_rsp_o.ready || dma_rsp_o.ready)
      else $error("slave answer not passed back");
   a_clk_caps: assert property (lsb_clk_ok_o == (lsb_clk_hz_i <= `SBM_LSB_MAX_HZ)
      && hsb_clk_ok_o == (hsb_clk_hz_i <= `SBM_HSB_MAX_HZ))
      else $error("bridge clock limit wrong");
   a_boot_pc: assert property (boot_pc_o == `SBM_BOOT_PC)
      else $error("boot address wrong");
   c_error: cover property (cpu_rsp_o.error);
   c_ext: cover property (ext_req_o.valid && ext_rsp_i.ready);
   c_dma: cover property (dma_rsp_o.ready);
   c_ext_wait: cover property (ext_req_o.valid && !ext_rsp_i.ready);
endmodule // sbm_matrix_props
bind sbm_matrix sbm_matrix_props u_props (.clk_i, .rst_n_i, .cpu_req_i, .cpu_rsp_o, .dma_rsp_o, .ext_req_o,
   .ext_sel_o, .ext_rsp_i, .lsb_clk_hz_i, .hsb_clk_hz_i, .lsb_clk_ok_o, .hsb_clk_ok_o, .boot_pc_o);
`default_nettype wire

/* File: test/sbm_ext_slave.sv */
// Model of the slaves behind the matrix's shared outward port
`default_nettype none
module sbm_ext_slave (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Matrix side
   input wire sbm_pkg::sbm_req_t req_i,
   input wire logic [3:0] lat_i,
   output sbm_pkg::sbm_rsp_t rsp_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import sbm_pkg::*;
   logic [3:0] wait_r;
   logic [3:0] wait_nxt;
   logic tog_r;
   // Idle data toggles so a stale word is never mistaken for an answer
   always_comb begin
      rsp_o.ready = req_i.valid && wait_r == lat_i;
      rsp_o.error = 1'b0;
      rsp_o.rdata = rsp_o.ready ? req_i.addr ^ 32'h5A5A_5A5A : {32{tog_r}} ^ 32'hA5A5_A5A5;
      wait_nxt = (req_i.valid && !rsp_o.ready) ? wait_r + 4'h1 : 4'h0;
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wait_r <= 4'h0;
         tog_r <= 1'b0;
      end else begin
         wait_r <= wait_nxt;
         tog_r <= !tog_r;
      end
   end
endmodule // sbm_ext_slave
`default_nettype wire

/* File: test/system_bus_matrix_sram_test.sv */
// Self-checking bench of the two-master bus matrix
`default_nettype none
`include "sbm_defines.svh"
module system_bus_matrix_sram_test;
   timeunit 1ns;
   timeprecision 1ps;
   import sbm_pkg::*;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   sbm_req_t rq [2];
   sbm_rsp_t rs [2];
   sbm_rsp_t got [2];
   sbm_slave_t sel [2];
   logic [31:0] xa [2];
   int fin [2];
   sbm_req_t ext_req;
   sbm_slave_t ext_sel;
   sbm_rsp_t ext_rsp;
   logic [31:0] lhz = 32'h0;
   logic [31:0] hhz = 32'h0;
   logic lok;
   logic hok;
   logic [1:0] remap = 2'h0;
   logic pd = 1'b0;
   logic [3:0] lat = 4'h0;
   logic [31:0] bpc;
   logic lastm;
   int mismatches = 0;
   int samples_checked = 0;
   sbm_matrix u_dut (.clk_i, .rst_n_i, .cpu_req_i(rq[0]), .cpu_rsp_o(rs[0]), .dma_req_i(rq[1]), .dma_rsp_o(rs[1]),
      .ext_req_o(ext_req), .ext_sel_o(ext_sel), .ext_rsp_i(ext_rsp), .lsb_clk_hz_i(lhz), .hsb_clk_hz_i(hhz),
      .lsb_clk_ok_o(lok), .hsb_clk_ok_o(hok), .vector_table_remap_register_i(remap), .power_down_mode_i(pd),
      .boot_pc_o(bpc), .last_master_o(lastm));
   sbm_ext_slave u_slave (.clk_i, .rst_n_i, .req_i(ext_req), .lat_i(lat), .rsp_o(ext_rsp));
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   task automatic test_done;
      $display("Checked %0d, mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_sel(input sbm_slave_t e, input sbm_slave_t g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("Error slave select expected %h seen %h", e, g);
      end
   endtask
   // One transfer: hold the request until ready, then a spare cycle
   task automatic acc(input int m, input logic w, input logic [1:0] sz, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      rq[m] <= '{1'b1, w, sz, a, d};
      sel[m] = SBM_SL_NONE;
      do begin
         @(posedge clk_i);
         #1;
         n++;
         if (ext_req.valid === 1'b1) begin
            sel[m] = ext_sel;
            xa[m] = ext_req.addr;
         end
      end while (rs[m].ready !== 1'b1 && n < 40);
      if (rs[m].ready !== 1'b1) begin
         mismatches++;
         $display("Error ready expected 1 seen %b", rs[m].ready);
         test_done();
      end
      got[m] = rs[m];
      fin[m] = n;
      @(posedge clk_i);
      #1;
      rq[m].valid <= 1'b0;
      @(posedge clk_i);
      #1;
   endtask
   task automatic t_sram;
      acc(0, 1, `SBM_SZ_WORD, `SBM_SRAM_BASE, 32'h4433_2211);
      acc(0, 1, `SBM_SZ_BYTE, `SBM_SRAM_BASE + 32'h1, 32'hAAAA_AAAA);
      acc(0, 1, `SBM_SZ_HALF, `SBM_SRAM_BASE + 32'h2, 32'hBEEF_BEEF);
      acc(1, 0, `SBM_SZ_WORD, `SBM_SRAM_BASE, 32'h0);
      chk("sram lanes", 32'hBEEF_AA11, got[1].rdata);
      acc(1, 1, `SBM_SZ_WORD, `SBM_SRAM_LAST - 32'h3, 32'h1357_9BDF);
      acc(0, 0, `SBM_SZ_BYTE, `SBM_SRAM_LAST, 32'h0);
      chk("top byte", 32'h13, {24'h0, got[0].rdata[31:24]});
      $display("Test sram done");
   endtask
   task automatic t_err;
      acc(0, 0, `SBM_SZ_WORD, `SBM_AHB_RSVD, 32'h0);
      chk("reserved error", 32'h1, {31'h0, got[0].error});
      acc(1, 1, `SBM_SZ_WORD, `SBM_SRAM_LAST + 32'h1, 32'h0);
      chk("past sram error", 32'h1, {31'h0, got[1].error});
      $display("Test errors done");
   endtask
   task automatic t_route;
      logic [31:0] ad [9] = '{32'h4000_0400, 32'h4000_73FC, 32'h4001_0000, 32'h4001_47FC, 32'h4002_8000,
         32'h4002_BFFC, 32'h4002_0800, 32'h4002_0000, 32'h0100_0000};
      sbm_slave_t sl [9] = '{SBM_SL_LSB, SBM_SL_LSB, SBM_SL_HSB, SBM_SL_HSB, SBM_SL_RADIO, SBM_SL_RADIO,
         SBM_SL_ADC, SBM_SL_AHB1, SBM_SL_MEM};
      for (int i = 0; i < 9; i++) begin
         lat = i[3:0];
         acc(i % 2, 0, `SBM_SZ_WORD, ad[i], 32'h0);
         chk_sel(sl[i], sel[i % 2]);
         chk("route data", ad[i] ^ 32'h5A5A_5A5A, got[i % 2].rdata);
      end
      remap = `SBM_REMAP_FLASH;
      acc(0, 0, `SBM_SZ_WORD, 32'h0000_0010, 32'h0);
      chk("vector remap", 32'h0100_0010, xa[0]);
      remap = `SBM_REMAP_ROM;
      $display("Test routes done");
   endtask
   task automatic t_arb;
      for (int k = 0; k < 2; k++) begin
         acc(k, 0, `SBM_SZ_WORD, `SBM_SRAM_BASE, 32'h0);
         chk("last master", k, {31'h0, lastm});
         fork
            acc(0, 0, `SBM_SZ_WORD, `SBM_SRAM_BASE, 32'h0);
            acc(1, 0, `SBM_SZ_WORD, `SBM_SRAM_BASE + 32'h4, 32'h0);
         join
         chk("rotation winner", 32'h1, fin[1 - k]);
         chk("rotation loser", 32'h3, fin[k]);
      end
      $display("Test arbitration done");
   endtask
   // Reset in mid-run: last master reset to DMA, memory kept, first access after release served
   task automatic t_reset;
      acc(0, 0, `SBM_SZ_WORD, `SBM_SRAM_BASE, 32'h0);
      chk("last master", 32'h0, {31'h0, lastm});
      rst_n_i = 1'b0;
      @(posedge clk_i);
      #1;
      chk("reset last master", 32'h1, {31'h0, lastm});
      chk_sel(SBM_SL_NONE, ext_sel);
      rst_n_i = 1'b1;
      repeat (3) @(posedge clk_i);
      #1;
      acc(1, 0, `SBM_SZ_WORD, `SBM_SRAM_BASE, 32'h0);
      chk("sram after reset", 32'hBEEF_AA11, got[1].rdata);
      $display("Test reset done");
   endtask
   task automatic t_misc;
      logic [31:0] v [4] = '{32'h01E8_4800, 32'h01E8_4801, 32'h03D0_9000, 32'h03D0_9001};
      acc(0, 1, `SBM_SZ_WORD, `SBM_SRAM_BASE + 32'h8, 32'hCAFE_F00D);
      pd = 1'b1;
      acc(0, 0, `SBM_SZ_WORD, `SBM_SRAM_BASE + 32'h8, 32'h0);
      chk("power down read", 32'h0, got[0].rdata);
      pd = 1'b0;
      for (int i = 0; i < 4; i++) begin
         lhz = v[i];
         hhz = v[i];
         @(posedge clk_i);
         #1;
         chk("low bridge ok", {31'h0, i == 0}, {31'h0, lok});
         chk("high bridge ok", {31'h0, i != 3}, {31'h0, hok});
      end
      chk("boot pc", 32'h0100_0000, bpc);
      $display("Test misc done");
   endtask
   initial begin
      rq[0] = '0;
      rq[1] = '0;
      repeat (5) @(posedge clk_i);
      #1;
      rst_n_i = 1'b1;
      repeat (3) @(posedge clk_i);
      #1;
      t_sram();
      t_err();
      t_route();
      t_arb();
      t_reset();
      t_misc();
      test_done();
   end
endmodule // system_bus_matrix_sram_test
`default_nettype wire
